// File: adcc_assertions.sv
// Port-level checker for the converter control logic
`timescale 1ns/1ns
module adcc_assertions
(
	input wire logic                    I_SYS_CLK,
	input wire logic                    I_RESET,
	input wire logic                    I_HALT,
	input wire logic                    I_CORE_DONE,
	input wire logic [31:0]             O_HRDATA,
	input wire logic                    O_CORE_CLK,
	input wire logic                    O_CORE_POWER,
	input wire logic                    O_CORE_START,
	input wire logic                    O_CORE_ABORT,
	input wire adcc_pkg::adcc_chan_type O_CHANNEL,
	input wire logic                    O_STABLE
);
	import adcc_pkg::*;
	logic busy;
	// ==================================================================
	// Conversion in flight, seen from the core side
	always_ff @(posedge I_SYS_CLK)
		if (I_RESET || O_CORE_ABORT || !O_CORE_POWER || I_CORE_DONE)
			busy <= 1'b0;
		else if (O_CORE_START)
			busy <= 1'b1;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RESET);
	// ==================================================================
	// Properties
	property p_restart;
		busy && I_CORE_DONE && !O_CORE_ABORT |=>
			##[0:1] (O_CORE_START || !O_CORE_POWER);
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_start_pulse;
		O_CORE_START |=> !O_CORE_START;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("long start");
	property p_off_quiet;
		!O_CORE_POWER |-> !O_CORE_START;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("start while off");
	property p_clk_off;
		!O_CORE_POWER ##1 !O_CORE_POWER |-> !O_CORE_CLK;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock while off");
	property p_clk_high;
		O_CORE_CLK ##1 O_CORE_CLK |=> !O_CORE_CLK;
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("clock high long");
	property p_halt_off;
		I_HALT ##1 I_HALT |-> !O_CORE_POWER && !O_CORE_START;
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("on in halt");
	property p_settle;
		!O_STABLE |-> !O_CORE_START;
	endproperty
	a_settle: assert property (p_settle) else $error("start unsettled");
	property p_chan_abort;
		$past(busy) && $changed(O_CHANNEL) |-> $past(O_CORE_ABORT);
	endproperty
	a_chan_abort: assert property (p_chan_abort) else $error("no abort");
	property p_chan_start;
		$changed(O_CHANNEL) && O_CORE_POWER && O_STABLE |->
			##[0:3] (O_CORE_START || !O_CORE_POWER);
	endproperty
	a_chan_start: assert property (p_chan_start) else $error("no start");
	property p_rdata;
		O_HRDATA[31:8] == 24'h000000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("upper data set");
	property p_reset;
		@(posedge I_SYS_CLK) disable iff (1'b0)
		I_RESET |=> !O_CORE_POWER && O_CHANNEL == 4'h0 && O_STABLE;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	c_start: cover property (O_CORE_START);
	c_abort: cover property (O_CORE_ABORT);
	c_done: cover property (busy && I_CORE_DONE);
endmodule : adcc_assertions

bind adcc_top adcc_assertions u_chk
(
	.I_SYS_CLK    (I_SYS_CLK),
	.I_RESET      (I_RESET),
	.I_HALT       (I_HALT),
	.I_CORE_DONE  (I_CORE_DONE),
	.O_HRDATA     (O_HRDATA),
	.O_CORE_CLK   (O_CORE_CLK),
	.O_CORE_POWER (O_CORE_POWER),
	.O_CORE_START (O_CORE_START),
	.O_CORE_ABORT (O_CORE_ABORT),
	.O_CHANNEL    (O_CHANNEL),
	.O_STABLE     (O_STABLE)
);

// File: adcc_core_model.sv
// Behavioural analog multiplexer and conversion core
`timescale 1ns/1ns
module adcc_core_model
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic       i_power,
	input  wire logic       i_start,
	input  wire logic       i_abort,
	input  wire logic [3:0] i_channel,
	input  wire logic       i_slow,
	input  wire logic       i_over,
	input  wire logic       i_under,
	output logic            o_done,
	output logic [9:0]      o_data,
	output logic            o_over,
	output logic            o_under
);
	logic       run;
	logic [4:0] cnt;
	logic [3:0] ch;
	// ==================================================================
	// Conversion timer
	always_ff @(posedge i_sys_clk)
	begin
		o_done <= 1'b0;
		if (i_reset || !i_power || i_abort)
			run <= 1'b0;
		else if (i_start)
		begin
			run <= 1'b1;
			ch  <= i_channel;
			cnt <= i_slow ? 5'h14 : 5'h04;
		end
		else if (run)
		begin
			cnt <= cnt - 5'h01;
			if (cnt == 5'h01)
			begin
				run    <= 1'b0;
				o_done <= 1'b1;
			end
		end
	end
	// Result lines carry rubbish outside the done cycle
	assign o_data  = o_done ? {ch, 6'h2D} : ~{ch, 6'h2D};
	assign o_over  = o_done ? i_over : ~i_over;
	assign o_under = o_done ? i_under : ~i_under;
endmodule : adcc_core_model

// File: adcc_params.svh
// Offsets, field positions, reset values and timing counts of the converter
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ==========================================================================
// Register indices and byte addresses
`define ADCC_IDX_CSR        8'h70
`define ADCC_IDX_HIGH       8'h71
`define ADCC_IDX_LOW        8'h72
`define ADCC_IDX_EVT        8'h73
`define ADCC_IDX_MASK       8'h74
`define ADCC_ADDR_CSR       12'h1C0
`define ADCC_ADDR_HIGH      12'h1C4
`define ADCC_ADDR_LOW       12'h1C8
`define ADCC_ADDR_EVT       12'h1CC
`define ADCC_ADDR_MASK      12'h1D0

// ==========================================================================
// Control/status fields
`define ADCC_BIT_EOC        7
`define ADCC_BIT_SPEED      6
`define ADCC_BIT_ON         5
`define ADCC_BIT_RSVD       4
`define ADCC_CH_MSB         3
`define ADCC_CH_LSB         0
`define ADCC_RESET_BYTE     8'h00

// ==========================================================================
// Event bits
`define ADCC_EVT_DONE       0
`define ADCC_EVT_OVERRUN    1
`define ADCC_EVT_ABORT      2
`define ADCC_EVT_WIDTH      3

// ==========================================================================
// Result saturation values
`define ADCC_RESULT_MAX     10'h3FF
`define ADCC_RESULT_MIN     10'h000

// ==========================================================================
// Timing
`define ADCC_CLK_PERIOD_NS  50
`define ADCC_STAB_NS        10000
`define ADCC_STAB_CYCLES    ((`ADCC_STAB_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_STAB_WIDTH     16

`endif

// File: adcc_pkg.sv
// Types shared by the converter control logic
package adcc_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [3:0]
	{
		ADCC_OFF   = 4'b0001,
		ADCC_STAB  = 4'b0010,
		ADCC_START = 4'b0100,
		ADCC_BUSY  = 4'b1000
	} adcc_state_type;

	typedef logic [3:0] adcc_chan_type;
	typedef logic [9:0] adcc_result_type;

endpackage : adcc_pkg

// File: adcc_top.sv
// Converter control logic with AHB-Lite register slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "adcc_params.svh"

module adcc_top
(
	input  wire logic                  I_SYS_CLK,
	input  wire logic                  I_RESET,
	input  wire logic                  I_HSEL,
	input  wire logic [31:0]           I_HADDR,
	input  wire logic [1:0]            I_HTRANS,
	input  wire logic                  I_HWRITE,
	input  wire logic [2:0]            I_HSIZE,
	input  wire logic [31:0]           I_HWDATA,
	input  wire logic                  I_HREADY,
	output logic      [31:0]           O_HRDATA,
	output logic                       O_HREADYOUT,
	output logic                       O_HRESP,
	input  wire logic                  I_HALT,
	input  wire logic                  I_CORE_DONE,
	input  wire adcc_pkg::adcc_result_type I_CORE_DATA,
	input  wire logic                  I_CORE_OVER,
	input  wire logic                  I_CORE_UNDER,
	output logic                       O_CORE_CLK,
	output logic                       O_CORE_POWER,
	output logic                       O_CORE_START,
	output logic                       O_CORE_ABORT,
	output adcc_pkg::adcc_chan_type    O_CHANNEL,
	output logic                       O_STABLE,
	output logic                       O_IRQ
);
	import adcc_pkg::*;

	// ======================================================================
	// Declarations
	adcc_state_type                    state;
	adcc_state_type                    next_state;
	logic                              speed;
	logic                              converter_on;
	adcc_chan_type                     channel_select_field;
	logic                              eoc;
	adcc_result_type                   result;
	logic [`ADCC_EVT_WIDTH-1:0]        evt;
	logic [`ADCC_EVT_WIDTH-1:0]        evt_mask;
	logic                              stab_pending;
	logic [`ADCC_STAB_WIDTH-1:0]       stab_cnt;
	logic                              div_cnt;
	logic                              core_clk;
	logic                              wr_pending;
	logic [11:0]                       wr_addr;
	logic [31:0]                       rdata;
	logic                              accept;
	logic                              rd_req;
	logic                              wr_csr;
	logic                              wr_evt;
	logic                              wr_mask;
	logic                              rd_high;
	logic                              run;
	logic                              chan_change;
	logic                              done_ok;
	logic                              abort_now;
	adcc_result_type                   sat_result;
	logic                              next_speed;
	logic                              next_on;
	adcc_chan_type                     next_chan;
	logic                              next_eoc;
	logic [`ADCC_EVT_WIDTH-1:0]        next_mask;
	logic [7:0]                        next_csr_byte;
	logic [31:0]                       next_rdata;

	// ======================================================================
	// Bus decode
	assign accept = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign rd_req = accept && !I_HWRITE;
	assign rd_high = rd_req && (I_HADDR[11:0] == `ADCC_ADDR_HIGH);
	assign wr_csr = wr_pending && (wr_addr == `ADCC_ADDR_CSR);
	assign wr_evt = wr_pending && (wr_addr == `ADCC_ADDR_EVT);
	assign wr_mask = wr_pending && (wr_addr == `ADCC_ADDR_MASK);
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;
	assign O_HRDATA = rdata;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			wr_pending <= 1'b0;
			wr_addr <= 12'h000;
		end
		else
		begin
			wr_pending <= accept && I_HWRITE;
			wr_addr <= I_HADDR[11:0];
		end
	end

	// ======================================================================
	// Control register next values
	always_comb
	begin
		next_speed = speed;
		next_on = converter_on;
		next_chan = channel_select_field;
		next_mask = evt_mask;
		if (wr_csr)
		begin
			next_speed = I_HWDATA[`ADCC_BIT_SPEED];
			next_on = I_HWDATA[`ADCC_BIT_ON];
			next_chan = I_HWDATA[`ADCC_CH_MSB:`ADCC_CH_LSB];
		end
		if (wr_mask)
		begin
			next_mask = I_HWDATA[`ADCC_EVT_WIDTH-1:0];
		end
	end

	// A new channel only restarts when the field really changes
	assign chan_change = wr_csr && (next_chan != channel_select_field);

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			speed <= 1'b0;
			converter_on <= 1'b0;
			channel_select_field <= 4'h0;
			evt_mask <= '0;
		end
		else
		begin
			speed <= next_speed;
			converter_on <= next_on;
			channel_select_field <= next_chan;
			evt_mask <= next_mask;
		end
	end

	// ======================================================================
	// Sequencer
	// Wait mode has no input here: conversion carries on untouched
	assign run = converter_on && !I_HALT;

	always_comb
	begin
		next_state = state;
		unique case (state)
			ADCC_OFF:
			begin
				if (run)
				begin
					next_state = stab_pending ? ADCC_STAB : ADCC_START;
				end
			end
			ADCC_STAB:
			begin
				if (!run)
				begin
					next_state = ADCC_OFF;
				end
				else if (stab_cnt == '0)
				begin
					next_state = ADCC_START;
				end
			end
			ADCC_START:
			begin
				if (!run)
				begin
					next_state = ADCC_OFF;
				end
				else if (!chan_change)
				begin
					next_state = ADCC_BUSY;
				end
			end
			ADCC_BUSY:
			begin
				if (!run)
				begin
					next_state = ADCC_OFF;
				end
				else if (chan_change || I_CORE_DONE)
				begin
					next_state = ADCC_START;
				end
			end
			default:
			begin
				next_state = ADCC_OFF;
			end
		endcase
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			state <= ADCC_OFF;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign O_CORE_START = (state == ADCC_START) && run && !chan_change;
	assign abort_now = (state == ADCC_BUSY) && (!run || chan_change);
	assign O_CORE_ABORT = abort_now;
	assign O_CORE_POWER = (state != ADCC_OFF);
	assign O_CHANNEL = channel_select_field;
	assign O_STABLE = !stab_pending;

	// ======================================================================
	// Settle time after halt
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			stab_pending <= 1'b0;
		end
		else if (I_HALT)
		begin
			stab_pending <= 1'b1;
		end
		else if ((state == ADCC_STAB) && (stab_cnt == '0))
		begin
			stab_pending <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			stab_cnt <= '0;
		end
		else if (state != ADCC_STAB)
		begin
			stab_cnt <= `ADCC_STAB_WIDTH'(`ADCC_STAB_CYCLES - 1);
		end
		else if (stab_cnt != '0)
		begin
			stab_cnt <= stab_cnt - `ADCC_STAB_WIDTH'(1);
		end
	end

	// ======================================================================
	// Converter clock divider
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET || (state == ADCC_OFF))
		begin
			div_cnt <= 1'b0;
			core_clk <= 1'b0;
		end
		else
		begin
			div_cnt <= !div_cnt;
			core_clk <= (speed || div_cnt) ? !core_clk : core_clk;
		end
	end

	assign O_CORE_CLK = core_clk;

	// ======================================================================
	// Result capture
	assign sat_result = I_CORE_OVER ? `ADCC_RESULT_MAX :
		(I_CORE_UNDER ? `ADCC_RESULT_MIN : I_CORE_DATA);

	assign done_ok = (state == ADCC_BUSY) && I_CORE_DONE && !abort_now;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			result <= `ADCC_RESULT_MIN;
		end
		else if (done_ok)
		begin
			result <= sat_result;
		end
	end

	// ======================================================================
	// End-of-conversion flag: completion wins over a clear
	always_comb
	begin
		next_eoc = eoc;
		if (rd_high || wr_csr)
		begin
			next_eoc = 1'b0;
		end
		if (done_ok)
		begin
			next_eoc = 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			eoc <= 1'b0;
		end
		else
		begin
			eoc <= next_eoc;
		end
	end

	// ======================================================================
	// Event status and interrupt
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			evt <= '0;
		end
		else
		begin
			evt[`ADCC_EVT_DONE] <= done_ok ||
				(evt[`ADCC_EVT_DONE] &&
				!(wr_evt && I_HWDATA[`ADCC_EVT_DONE]));
			evt[`ADCC_EVT_OVERRUN] <= (done_ok && eoc) ||
				(evt[`ADCC_EVT_OVERRUN] &&
				!(wr_evt && I_HWDATA[`ADCC_EVT_OVERRUN]));
			evt[`ADCC_EVT_ABORT] <= abort_now ||
				(evt[`ADCC_EVT_ABORT] &&
				!(wr_evt && I_HWDATA[`ADCC_EVT_ABORT]));
		end
	end

	assign O_IRQ = |(evt & evt_mask);

	// ======================================================================
	// Read data, taken at the address phase; control and mask from post-write values, event status from the current bits
	always_comb
	begin
		next_csr_byte = {next_eoc, next_speed, next_on, 1'b0, next_chan};
		next_rdata = 32'h0000_0000;
		unique case (I_HADDR[11:0])
			`ADCC_ADDR_CSR:
			begin
				next_rdata[7:0] = next_csr_byte;
			end
			`ADCC_ADDR_HIGH:
			begin
				next_rdata[7:0] = result[9:2];
			end
			`ADCC_ADDR_LOW:
			begin
				next_rdata[7:0] = {6'h00, result[1:0]};
			end
			`ADCC_ADDR_EVT:
			begin
				next_rdata[`ADCC_EVT_WIDTH-1:0] = evt;
			end
			`ADCC_ADDR_MASK:
			begin
				next_rdata[`ADCC_EVT_WIDTH-1:0] = next_mask;
			end
			default:
			begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			rdata <= 32'h0000_0000;
		end
		else if (rd_req)
		begin
			rdata <= next_rdata;
		end
	end

endmodule : adcc_top

// File: adcc_top_tb_top.sv
// Register-level testbench of the converter control logic
`timescale 1ns/1ns
`include "adcc_params.svh"
module adcc_top_tb_top;
	import adcc_pkg::*;
	logic            clk, rst, hsel, hwrite, halt, slow, f_over, f_under;
	logic [31:0]     haddr, hwdata, hrdata, q;
	logic [1:0]      htrans;
	logic            hrdy, hresp, done, over, under, cclk, pwr, start;
	logic            abort, stab, irq;
	adcc_result_type data;
	adcc_chan_type   chan;
	int              errors = 0, total_checks = 0, cyc = 0, n, k;
	// ==================================================================
	// Design and core model
	adcc_top u_dut
	(
		.I_SYS_CLK    (clk),
		.I_RESET      (rst),
		.I_HSEL       (hsel),
		.I_HADDR      (haddr),
		.I_HTRANS     (htrans),
		.I_HWRITE     (hwrite),
		.I_HSIZE      (3'h2),
		.I_HWDATA     (hwdata),
		.I_HREADY     (hrdy),
		.O_HRDATA     (hrdata),
		.O_HREADYOUT  (hrdy),
		.O_HRESP      (hresp),
		.I_HALT       (halt),
		.I_CORE_DONE  (done),
		.I_CORE_DATA  (data),
		.I_CORE_OVER  (over),
		.I_CORE_UNDER (under),
		.O_CORE_CLK   (cclk),
		.O_CORE_POWER (pwr),
		.O_CORE_START (start),
		.O_CORE_ABORT (abort),
		.O_CHANNEL    (chan),
		.O_STABLE     (stab),
		.O_IRQ        (irq)
	);
	adcc_core_model u_core
	(
		.i_sys_clk (clk),
		.i_reset   (rst),
		.i_power   (pwr),
		.i_start   (start),
		.i_abort   (abort),
		.i_channel (chan),
		.i_slow    (slow),
		.i_over    (f_over),
		.i_under   (f_under),
		.o_done    (done),
		.o_data    (data),
		.o_over    (over),
		.o_under   (under)
	);
	// ==================================================================
	// Bus and check tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0, a};
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, 32'(e));
	endtask : rdc
	task automatic wait_flag;
		q = 32'h0;
		for (k = 0; k < 300 && q[7] !== 1'b1; k++) bus(1'b0, `ADCC_ADDR_CSR, 8'h00);
		chk(32'(q[7]), 32'h1);
		q = 32'h0;
	endtask : wait_flag
	task automatic period(input int exp);
		int p;
		p = 0;
		do @(posedge clk); while (cclk !== 1'b0);
		do @(posedge clk); while (cclk !== 1'b1);
		do begin @(posedge clk); p++; end while (cclk !== 1'b0);
		do begin @(posedge clk); p++; end while (cclk !== 1'b1);
		chk(32'(p), 32'(exp));
	endtask : period
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// ==================================================================
	// Clock, timeout and tests
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			errors++;
			end_of_test();
		end
	end
	initial
	begin
		{hsel, hwrite, halt, f_over, f_under} = 5'h00;
		{haddr, hwdata, htrans, q} = 98'h0;
		slow = 1'b1;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (n = 0; n < 6; n++) rdc(12'h1C0 + 12'(n * 4), 8'h00);
		chk({28'h0, chan}, 32'h0);
		chk(32'(stab), 32'h1);
		chk(32'(hresp), 32'h0);
		$display("test reset done");
		bus(1'b1, `ADCC_ADDR_CSR, 8'h2F);
		period(4);
		wait_flag();
		rdc(`ADCC_ADDR_LOW, 8'h01);
		rdc(`ADCC_ADDR_CSR, 8'hAF);
		rdc(`ADCC_ADDR_HIGH, 8'hFB);
		rdc(`ADCC_ADDR_CSR, 8'h2F);
		$display("test read order done");
		for (n = 0; n < 16; n++)
		begin
			bus(1'b1, `ADCC_ADDR_CSR, {4'h6, n[3:0]});
			rdc(`ADCC_ADDR_CSR, {4'h6, n[3:0]});
			wait_flag();
			chk({28'h0, chan}, 32'(n[3:0]));
			rdc(`ADCC_ADDR_HIGH, {n[3:0], 4'hB});
		end
		period(2);
		$display("test channels done");
		for (n = 0; n < 3; n++)
		begin
			f_over  <= (n != 1);
			f_under <= (n > 0);
			bus(1'b1, `ADCC_ADDR_CSR, 8'h6F);
			wait_flag();
			rdc(`ADCC_ADDR_LOW, (n == 1) ? 8'h00 : 8'h03);
			rdc(`ADCC_ADDR_HIGH, (n == 1) ? 8'h00 : 8'hFF);
		end
		f_under <= 1'b0;
		bus(1'b1, `ADCC_ADDR_CSR, 8'h6F);
		wait_flag();
		f_over <= 1'b0;
		@(posedge done);
		@(posedge clk);
		rdc(`ADCC_ADDR_LOW, 8'h01);
		$display("test saturation done");
		chk(32'(irq), 32'h0);
		bus(1'b1, `ADCC_ADDR_MASK, 8'h01);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h1);
		bus(1'b1, `ADCC_ADDR_CSR, 8'h00);
		repeat (40) @(posedge clk);
		chk(32'(pwr), 32'h0);
		rdc(`ADCC_ADDR_CSR, 8'h00);
		bus(1'b1, `ADCC_ADDR_EVT, 8'h07);
		rdc(`ADCC_ADDR_EVT, 8'h00);
		chk(32'(irq), 32'h0);
		$display("test off and events done");
		bus(1'b1, `ADCC_ADDR_CSR, 8'h63);
		halt <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(pwr), 32'h0);
		halt <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(stab), 32'h0);
		for (k = 0; k < 400 && stab !== 1'b1; k++) @(posedge clk);
		wait_flag();
		rdc(`ADCC_ADDR_HIGH, 8'h3B);
		$display("test halt done");
		end_of_test();
	end
endmodule : adcc_top_tb_top
